//--- core/tcmp_defs.vh
// Constants of the 16-bit timer output compare block: register map,
// field positions, reset values and compare output mode codes.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
`ifndef TCMP_DEFS_VH
`define TCMP_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TCMP_OFS_CTRL     8'h00
`define TCMP_OFS_FORCE    8'h04
`define TCMP_OFS_FLAGS    8'h08
`define TCMP_OFS_CNT_LO   8'h0c
`define TCMP_OFS_CNT_HI   8'h10
`define TCMP_OFS_CMPA_LO  8'h14
`define TCMP_OFS_CMPA_HI  8'h18
`define TCMP_OFS_CMPB_LO  8'h1c
`define TCMP_OFS_CMPB_HI  8'h20
`define TCMP_OFS_PORT     8'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TCMP_CTRL_MODE_LSB  0
`define TCMP_CTRL_COMA_LSB  4
`define TCMP_CTRL_COMB_LSB  6
`define TCMP_CTRL_IEA_BIT   8
`define TCMP_CTRL_IEB_BIT   9
`define TCMP_CTRL_IEOV_BIT  10
`define TCMP_FLAG_OV_BIT    0
`define TCMP_FLAG_A_BIT     1
`define TCMP_FLAG_B_BIT     2
`define TCMP_PORT_DATA_LSB  0
`define TCMP_PORT_DIR_LSB   2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TCMP_CTRL_RST   11'h000
`define TCMP_PORT_RST   4'h0
`define TCMP_CMP_RST    16'h0000

// ------------------------------------------------------------
// Counter limits and fixed TOP values
// ------------------------------------------------------------
`define TCMP_MAX      16'hffff
`define TCMP_BOTTOM   16'h0000
`define TCMP_TOP_8B   16'h00ff
`define TCMP_TOP_9B   16'h01ff
`define TCMP_TOP_10B  16'h03ff

// ------------------------------------------------------------
// Compare output mode codes
// ------------------------------------------------------------
`define TCMP_COM_OFF     2'h0
`define TCMP_COM_TOGGLE  2'h1
`define TCMP_COM_CLEAR   2'h2
`define TCMP_COM_SET     2'h3

`endif

//--- core/tcmp_counter.v
// 16-bit timer counter core used by the compare block.
// Assumes tick_i is a one-cycle timer clock enable from an outside prescaler.
`timescale 1ns/1ps

module tcmp_counter (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        tick_i,
	input  wire        normal_i,
	input  wire        dual_i,
	input  wire        var_top_i,
	input  wire [15:0] top_i,
	input  wire        wr_i,
	input  wire [15:0] wr_val_i,
	output reg  [15:0] count_o,
	output reg         down_o,
	output reg         block_o,
	output wire        top_evt_o,
	output wire        bottom_evt_o,
	output wire        ovf_evt_o
);
	`include "tcmp_defs.vh"

	wire hit_top;

	// A blocked match also hides the TOP match in variable-TOP modes
	assign hit_top      = (count_o == top_i) && !(block_o && var_top_i) && !normal_i;  // [R13]
	assign top_evt_o    = tick_i && !wr_i && hit_top;
	assign bottom_evt_o = tick_i && !wr_i && (count_o == `TCMP_BOTTOM);
	assign ovf_evt_o    = dual_i ? (bottom_evt_o && down_o)
	                    : (hit_top ? top_evt_o : (tick_i && !wr_i && count_o == `TCMP_MAX));  // [R22]

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= `TCMP_BOTTOM;
			down_o  <= 1'b0;
			block_o <= 1'b0;
		end else if (wr_i) begin
			count_o <= wr_val_i;  // [R23]
			block_o <= 1'b1;      // [R12]
		end else if (tick_i) begin
			block_o <= 1'b0;
			if (!dual_i) begin
				down_o <= 1'b0;
				if (hit_top)
					count_o <= `TCMP_BOTTOM;
				else
					count_o <= count_o + 16'h0001;  // [R21]
			end else if (!down_o) begin
				if (hit_top) begin
					down_o  <= 1'b1;
					count_o <= count_o - 16'h0001;
				end else begin
					count_o <= count_o + 16'h0001;
				end
			end else begin
				if (count_o == `TCMP_BOTTOM) begin
					down_o  <= 1'b0;
					count_o <= count_o + 16'h0001;
				end else begin
					count_o <= count_o - 16'h0001;
				end
			end
		end
	end

endmodule // tcmp_counter

//--- core/tcmp_channel.v
// One output compare channel: compare registers, comparator, match flag
// and compare output state. Assumes counter events come from tcmp_counter.
`timescale 1ns/1ps

module tcmp_channel (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        tick_i,
	input  wire [15:0] count_i,
	input  wire        block_i,
	input  wire        down_i,
	input  wire        pwm_i,
	input  wire        dual_i,
	input  wire        upd_bottom_i,
	input  wire        top_evt_i,
	input  wire        bottom_evt_i,
	input  wire        wr_i,
	input  wire [15:0] wr_val_i,
	input  wire [1:0]  com_i,
	input  wire        force_i,
	input  wire        flag_clr_i,
	output wire [15:0] ocr_view_o,
	output reg  [15:0] ocr_active_o,
	output reg         flag_o,
	output reg         state_o
);
	`include "tcmp_defs.vh"

	reg  [15:0] ocr_buf;
	wire        equal;
	wire        match;
	wire        upd;
	reg         next_state;

	assign equal      = (count_i == ocr_active_o);              // [R1]
	// Equality seen during the last tick period acts on the next tick
	assign match      = tick_i && equal && !block_i;            // [R2] [R12]
	assign upd        = upd_bottom_i ? bottom_evt_i : top_evt_i;
	assign ocr_view_o = pwm_i ? ocr_buf : ocr_active_o;         // [R8] [R9]

	// ------------------------------------------------------------
	// Compare registers
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			ocr_buf      <= `TCMP_CMP_RST;
			ocr_active_o <= `TCMP_CMP_RST;
		end else begin
			if (wr_i)
				ocr_buf <= wr_val_i;          // [R10]
			if (wr_i && !pwm_i)
				ocr_active_o <= wr_val_i;     // [R6] [R8]
			else if (pwm_i && upd)
				ocr_active_o <= ocr_buf;      // [R7]
		end
	end

	// ------------------------------------------------------------
	// Match flag: a set in the clearing cycle wins
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i)
			flag_o <= 1'b0;
		else
			flag_o <= match | (flag_o & ~flag_clr_i);  // [R3] [R4]
	end

	// ------------------------------------------------------------
	// Output state
	// ------------------------------------------------------------
	always @* begin
		next_state = state_o;
		if (!pwm_i) begin
			if (match || force_i) begin  // [R11] [R15]
				case (com_i)                 // [R20]
				`TCMP_COM_TOGGLE: next_state = ~state_o;
				`TCMP_COM_CLEAR:  next_state = 1'b0;
				`TCMP_COM_SET:    next_state = 1'b1;
				default:          next_state = state_o;  // [R18]
				endcase
			end
		end else if (com_i[1]) begin
			if (dual_i) begin
				if (match)
					next_state = down_i ? ~com_i[0] : com_i[0];
			end else begin
				if (match)
					next_state = com_i[0];
				// Restart at BOTTOM wins so TOP-equal compare gives full duty
				if (top_evt_i)
					next_state = ~com_i[0];
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i)
			state_o <= 1'b0;         // [R16]
		else
			state_o <= next_state;   // [R14]
	end

endmodule // tcmp_channel

//--- core/tcmp_top.v
// Summary of operation
// (R1) Counter compared with each channel compare value every cycle.
// (R2) Match flag set at the timer tick after equality.
// (R3) Enabled flag raises interrupt; servicing clears it.
// (R4) Writing one clears a match flag; zero leaves it.
// (R5) Channel A compare can set the counter TOP.
// (R6) Compare value double buffered in the twelve PWM modes only.
// (R7) Buffered value loads at TOP or BOTTOM per mode.
// (R8) Bus reaches buffer when buffered, active register otherwise.
// (R9) Compare changes only by writes; bytes read directly.
// (R10) High byte goes to temp; low write loads all sixteen bits.
// (R11) Force strobe acts like a match in non-PWM modes, no flag.
// (R12) Counter write blocks the match of the next tick.
// (R13) Counter written to variable TOP loses TOP match, runs to max.
// (R14) Output state kept across waveform mode changes.
// (R15) Output mode change acts at next match or on force.
// (R16) Reset clears every output state to zero.
// (R17) Nonzero output mode overrides port value; direction bit gates pin.
// (R18) Output mode zero leaves output state untouched on match.
// (R19) Output mode bits never alter counting or capture.
// (R20) Non-PWM: set, clear, toggle; PWM: inverted or not.
// (R21) Normal mode counts up, wraps at max, writable anytime.
// (R22) Overflow flag set when count turns zero; counting never clears it.
// (R23) Counter write beats any count or clear in the same cycle.
//
// Top of the 16-bit timer output compare block with a Wishbone slave.
// Assumes timer_tick_i is a one-cycle enable from an outside prescaler.
`timescale 1ns/1ps

module tcmp_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        timer_tick_i,
	input  wire [15:0] capture_top_i,
	input  wire [2:0]  irq_serviced_i,
	output reg  [2:0]  irq_req_o,
	output reg  [1:0]  cmp_pin_o,
	output reg  [1:0]  cmp_pin_oe_o
);
	`include "tcmp_defs.vh"

	// ------------------------------------------------------------
	// Registers and wiring
	// ------------------------------------------------------------
	reg  [3:0]  waveform_mode_select;
	reg  [1:0]  compare_output_mode_a;
	reg  [1:0]  compare_output_mode_b;
	reg  [1:0]  compare_irq_enable;
	reg         overflow_irq_enable;
	reg  [1:0]  port_data;
	reg  [1:0]  compare_pin_direction_bit;
	reg  [7:0]  temp_high;
	reg         overflow_flag;

	wire        req;
	wire        wr_acc;
	wire        rd_acc;
	wire        lane0;
	wire [15:0] timer_count_value;
	wire        count_down;
	wire        match_block;
	wire        top_evt;
	wire        bottom_evt;
	wire        ovf_evt;
	wire [15:0] ocr_view_a;
	wire [15:0] ocr_view_b;
	wire [15:0] ocr_active_a;
	wire        compare_match_flag_a;
	wire        compare_match_flag_b;
	wire        compare_output_state_a;
	wire        compare_output_state_b;
	wire        cnt_wr;
	wire        cmpa_wr;
	wire        cmpb_wr;
	wire [1:0]  force_compare_strobe;
	wire [2:0]  flag_wclr;
	wire [15:0] wr_word;
	wire        mode_pwm;
	wire        mode_dual;
	wire        mode_upd_bottom;
	wire        mode_var_top;
	wire        mode_normal;
	reg  [15:0] top_value;
	reg  [31:0] next_rdata;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	function is_mode;
		input [3:0]  mode;
		input [15:0] set;
		begin
			is_mode = set[mode];
		end
	endfunction

	// Output mode bits take no part in counting or TOP choice
	assign mode_pwm        = is_mode(waveform_mode_select, 16'hcfee);  // [R6] [R19]
	assign mode_dual       = is_mode(waveform_mode_select, 16'h0f0e);
	assign mode_upd_bottom = is_mode(waveform_mode_select, 16'h0300);
	assign mode_var_top    = is_mode(waveform_mode_select, 16'hdf10);
	assign mode_normal     = is_mode(waveform_mode_select, 16'h2001);

	always @* begin
		case (waveform_mode_select)
		4'h1, 4'h5:                top_value = `TCMP_TOP_8B;
		4'h2, 4'h6:                top_value = `TCMP_TOP_9B;
		4'h3, 4'h7:                top_value = `TCMP_TOP_10B;
		4'h8, 4'ha, 4'hc, 4'he:    top_value = capture_top_i;
		4'h4, 4'h9, 4'hb, 4'hf:    top_value = ocr_active_a;  // [R5]
		default:                   top_value = `TCMP_MAX;
		endcase
	end

	// ------------------------------------------------------------
	// Wishbone slave: ack one cycle after the request, writes land on the ack edge
	// ------------------------------------------------------------
	assign req     = wb_cyc_i && wb_stb_i;
	assign wr_acc  = req && wb_ack_o && wb_we_i && lane0;
	assign rd_acc  = req && !wb_ack_o && !wb_we_i;
	assign lane0   = wb_sel_i[0];
	assign wr_word = {temp_high, wb_dat_i[7:0]};
	assign cnt_wr  = wr_acc && (wb_adr_i == `TCMP_OFS_CNT_LO);
	assign cmpa_wr = wr_acc && (wb_adr_i == `TCMP_OFS_CMPA_LO);  // [R10]
	assign cmpb_wr = wr_acc && (wb_adr_i == `TCMP_OFS_CMPB_LO);  // [R10]

	assign force_compare_strobe = (wr_acc && wb_adr_i == `TCMP_OFS_FORCE && !mode_pwm)
	                            ? wb_dat_i[1:0] : 2'h0;  // [R11]
	assign flag_wclr = (wr_acc && wb_adr_i == `TCMP_OFS_FLAGS) ? wb_dat_i[2:0] : 3'h0;  // [R4]

	always @* begin
		case (wb_adr_i)
		`TCMP_OFS_CTRL:    next_rdata = {21'h000000, overflow_irq_enable, compare_irq_enable,
		                                 compare_output_mode_b, compare_output_mode_a, waveform_mode_select};
		`TCMP_OFS_FLAGS:   next_rdata = {29'h00000000, compare_match_flag_b, compare_match_flag_a,
		                                 overflow_flag};
		`TCMP_OFS_CNT_LO:  next_rdata = {24'h000000, timer_count_value[7:0]};
		`TCMP_OFS_CNT_HI:  next_rdata = {24'h000000, temp_high};
		`TCMP_OFS_CMPA_LO: next_rdata = {24'h000000, ocr_view_a[7:0]};   // [R9]
		`TCMP_OFS_CMPA_HI: next_rdata = {24'h000000, ocr_view_a[15:8]};  // [R9]
		`TCMP_OFS_CMPB_LO: next_rdata = {24'h000000, ocr_view_b[7:0]};
		`TCMP_OFS_CMPB_HI: next_rdata = {24'h000000, ocr_view_b[15:8]};
		`TCMP_OFS_PORT:    next_rdata = {28'h0000000, compare_pin_direction_bit, port_data};
		default:           next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			if (rd_acc)
				wb_dat_o <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Control registers and shared high-byte temp
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			{overflow_irq_enable, compare_irq_enable, compare_output_mode_b,
			 compare_output_mode_a, waveform_mode_select} <= `TCMP_CTRL_RST;
			{compare_pin_direction_bit, port_data} <= `TCMP_PORT_RST;
			temp_high <= 8'h00;
		end else begin
			if (wr_acc && wb_adr_i == `TCMP_OFS_CTRL) begin
				// Output mode takes effect at the next match or force, no buffering
				waveform_mode_select  <= wb_dat_i[`TCMP_CTRL_MODE_LSB +: 4];
				compare_output_mode_a <= wb_dat_i[`TCMP_CTRL_COMA_LSB +: 2];  // [R15]
				compare_output_mode_b <= wb_dat_i[`TCMP_CTRL_COMB_LSB +: 2];
				compare_irq_enable    <= {wb_dat_i[`TCMP_CTRL_IEB_BIT], wb_dat_i[`TCMP_CTRL_IEA_BIT]};
				overflow_irq_enable   <= wb_dat_i[`TCMP_CTRL_IEOV_BIT];
			end
			if (wr_acc && wb_adr_i == `TCMP_OFS_PORT) begin
				port_data                 <= wb_dat_i[`TCMP_PORT_DATA_LSB +: 2];
				compare_pin_direction_bit <= wb_dat_i[`TCMP_PORT_DIR_LSB +: 2];
			end
			// One temp serves all 16-bit locations, as software must write high first
			if (wr_acc && (wb_adr_i == `TCMP_OFS_CNT_HI || wb_adr_i == `TCMP_OFS_CMPA_HI
			               || wb_adr_i == `TCMP_OFS_CMPB_HI))
				temp_high <= wb_dat_i[7:0];  // [R10]
			else if (rd_acc && wb_adr_i == `TCMP_OFS_CNT_LO)
				temp_high <= timer_count_value[15:8];
		end
	end

	// ------------------------------------------------------------
	// Overflow flag
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i)
			overflow_flag <= 1'b0;
		else
			overflow_flag <= ovf_evt | (overflow_flag & ~flag_wclr[`TCMP_FLAG_OV_BIT]
			                 & ~irq_serviced_i[`TCMP_FLAG_OV_BIT]);  // [R22]
	end

	// ------------------------------------------------------------
	// Counter and channels
	// ------------------------------------------------------------
	tcmp_counter u_counter (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.tick_i       (timer_tick_i),
		.normal_i     (mode_normal),
		.dual_i       (mode_dual),
		.var_top_i    (mode_var_top),
		.top_i        (top_value),
		.wr_i         (cnt_wr),
		.wr_val_i     (wr_word),
		.count_o      (timer_count_value),
		.down_o       (count_down),
		.block_o      (match_block),
		.top_evt_o    (top_evt),
		.bottom_evt_o (bottom_evt),
		.ovf_evt_o    (ovf_evt)
	);

	tcmp_channel u_chan_a (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.tick_i       (timer_tick_i),
		.count_i      (timer_count_value),
		.block_i      (match_block),
		.down_i       (count_down),
		.pwm_i        (mode_pwm),
		.dual_i       (mode_dual),
		.upd_bottom_i (mode_upd_bottom),
		.top_evt_i    (top_evt),
		.bottom_evt_i (bottom_evt),
		.wr_i         (cmpa_wr),
		.wr_val_i     (wr_word),
		.com_i        (compare_output_mode_a),
		.force_i      (force_compare_strobe[0]),
		.flag_clr_i   (flag_wclr[`TCMP_FLAG_A_BIT] | irq_serviced_i[`TCMP_FLAG_A_BIT]),  // [R3] [R4]
		.ocr_view_o   (ocr_view_a),
		.ocr_active_o (ocr_active_a),
		.flag_o       (compare_match_flag_a),
		.state_o      (compare_output_state_a)
	);

	tcmp_channel u_chan_b (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.tick_i       (timer_tick_i),
		.count_i      (timer_count_value),
		.block_i      (match_block),
		.down_i       (count_down),
		.pwm_i        (mode_pwm),
		.dual_i       (mode_dual),
		.upd_bottom_i (mode_upd_bottom),
		.top_evt_i    (top_evt),
		.bottom_evt_i (bottom_evt),
		.wr_i         (cmpb_wr),
		.wr_val_i     (wr_word),
		.com_i        (compare_output_mode_b),
		.force_i      (force_compare_strobe[1]),
		.flag_clr_i   (flag_wclr[`TCMP_FLAG_B_BIT] | irq_serviced_i[`TCMP_FLAG_B_BIT]),  // [R3] [R4]
		.ocr_view_o   (ocr_view_b),
		.ocr_active_o (),
		.flag_o       (compare_match_flag_b),
		.state_o      (compare_output_state_b)
	);

	// ------------------------------------------------------------
	// Interrupt requests and pin override, all registered
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o    <= 3'h0;
			cmp_pin_o    <= 2'h0;
			cmp_pin_oe_o <= 2'h0;
		end else begin
			irq_req_o    <= {compare_match_flag_b & compare_irq_enable[1],
			                 compare_match_flag_a & compare_irq_enable[0],
			                 overflow_flag & overflow_irq_enable};  // [R3]
			cmp_pin_o[0] <= (compare_output_mode_a != `TCMP_COM_OFF) ? compare_output_state_a : port_data[0];  // [R17]
			cmp_pin_o[1] <= (compare_output_mode_b != `TCMP_COM_OFF) ? compare_output_state_b : port_data[1];  // [R17]
			cmp_pin_oe_o <= compare_pin_direction_bit;  // [R17]
		end
	end

endmodule // tcmp_top

//--- dv/tcmp_properties.sv
// Checker of bus, interrupt and pin timing of the compare block.
// Assumes it sees only the top ports; bound at the foot.
`timescale 1ns/1ps
`include "tcmp_defs.vh"

module tcmp_checker (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        timer_tick_i,
	input wire [2:0]  irq_serviced_i,
	input wire [2:0]  irq_req_o,
	input wire [1:0]  cmp_pin_o,
	input wire [1:0]  cmp_pin_oe_o
);
	reg  rst_was;
	wire wr_ack = wb_ack_o && wb_we_i;

	always @(posedge clk_i) begin
		rst_was <= rst_i;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_rst_clear;
		rst_was && !rst_i |-> !wb_ack_o && irq_req_o == 3'h0 && cmp_pin_o == 2'h0 && cmp_pin_oe_o == 2'h0;
	endproperty
	property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	// Flags rise only at a tick; enabling may also expose a held flag
	property p_irq_rise; (irq_req_o & ~$past(irq_req_o)) != 3'h0 |-> $past(timer_tick_i, 2) || $past(wr_ack, 2);
	endproperty
	property p_irq_clr;
		irq_serviced_i != 3'h0 && !timer_tick_i |=> ##1 (irq_req_o & $past(irq_serviced_i, 2)) == 3'h0;
	endproperty
	property p_rd_zero;
		wb_ack_o && !wb_we_i && (wb_adr_i == `TCMP_OFS_FORCE || wb_adr_i > `TCMP_OFS_PORT) |-> wb_dat_o == 32'h0;
	endproperty
	property p_pin_cause; $changed(cmp_pin_o) |-> $past(timer_tick_i, 2) || $past(wr_ack, 2) || $past(wr_ack);
	endproperty
	property p_oe_cause;
		$changed(cmp_pin_oe_o) |-> $past(wr_ack && wb_adr_i == `TCMP_OFS_PORT, 2) || $past(wr_ack);
	endproperty

	a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
	a_ack_resp: assert property (p_ack_resp) else $error("ack late");
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	a_irq_clr: assert property (p_irq_clr) else $error("irq kept after service");
	a_rd_zero: assert property (p_rd_zero) else $error("read of empty place not zero");
	a_pin_cause: assert property (p_pin_cause) else $error("pin moved without cause");
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");

	c_irq: cover property ($rose(irq_req_o[1]));
	c_pin: cover property ($changed(cmp_pin_o));
	c_rd: cover property (wb_ack_o && !wb_we_i);
endmodule // tcmp_checker

bind tcmp_top tcmp_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.timer_tick_i(timer_tick_i), .irq_serviced_i(irq_serviced_i), .irq_req_o(irq_req_o),
	.cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o));

//--- dv/tcmp_cpu_model.sv
// CPU side bus master: classic Wishbone single cycles.
// Assumes one clock shared with the slave; the bench calls its tasks.
`timescale 1ns/1ps

module tcmp_cpu_model (
	input  wire        clk_i,
	input  wire        wb_ack_i,
	input  wire [31:0] wb_dat_i,
	output reg         wb_cyc_o,
	output reg         wb_stb_o,
	output reg         wb_we_o,
	output reg  [7:0]  wb_adr_o,
	output reg  [31:0] wb_dat_o
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_dat_o = 32'h0;
	end

	// Opening edge first, so a released strobe stays low a full cycle
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_dat_o <= d;
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_dat_o <= ~d;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	// High byte into the shared temp first, then the low byte loads all
	task wr16(input logic [7:0] ah, input logic [15:0] v);
		wr(ah, {24'h0, v[15:8]});
		wr(ah - 8'h04, {24'h0, v[7:0]});
	endtask
endmodule // tcmp_cpu_model

//--- dv/test_tcmp_top.sv
// Self-checking bench of the timer compare block.
// Assumes the CPU model drives the bus; ticks and service pulses come from here.
`timescale 1ns/1ps
`include "tcmp_defs.vh"

module test_tcmp_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        tick = 1'b0;
	logic [2:0]  svc = 3'h0;
	logic [31:0] q;
	wire         cyc, stb, we, ack;
	wire [7:0]   adr;
	wire [31:0]  wdat, rdat;
	wire [2:0]   irq;
	wire [1:0]   pin, oe;
	int          err_total = 0;
	int          total_checks = 0;

	always #5 clk_i = ~clk_i;

	tcmp_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.timer_tick_i(tick), .capture_top_i(16'hffff), .irq_serviced_i(svc), .irq_req_o(irq),
		.cmp_pin_o(pin), .cmp_pin_oe_o(oe));
	tcmp_cpu_model cpu (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
		.wb_we_o(we), .wb_adr_o(adr), .wb_dat_o(wdat));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		cpu.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task ticks(input int n);
		repeat (n) begin
			@(posedge clk_i) tick <= 1'b1;
			@(posedge clk_i) tick <= 1'b0;
		end
		repeat (2) @(posedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		chk({28'h0, oe, pin}, 32'h0);
		rd_chk(`TCMP_OFS_CTRL, 32'h0);
		rd_chk(`TCMP_OFS_CMPA_HI, 32'h0);
		rd_chk(8'h80, 32'h0);
	endtask
	task t_match;
		cpu.wr16(`TCMP_OFS_CMPA_HI, 16'h0105);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0100);
		ticks(5);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		ticks(1);
		rd_chk(`TCMP_OFS_FLAGS, 32'h2);
		cpu.wr(`TCMP_OFS_FLAGS, 32'h0);
		rd_chk(`TCMP_OFS_FLAGS, 32'h2);
		cpu.wr(`TCMP_OFS_FLAGS, 32'h2);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0105);
		ticks(1);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		rd_chk(`TCMP_OFS_CNT_LO, 32'h06);
		rd_chk(`TCMP_OFS_CNT_HI, 32'h01);
	endtask
	task t_irq;
		cpu.wr(`TCMP_OFS_CTRL, 32'h100);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0104);
		ticks(2);
		chk({29'h0, irq}, 32'h2);
		@(posedge clk_i) svc <= 3'h2;
		@(posedge clk_i) svc <= 3'h0;
		repeat (2) @(posedge clk_i);
		chk({29'h0, irq}, 32'h0);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		cpu.wr(`TCMP_OFS_CTRL, 32'h0);
	endtask
	task t_ovf;
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'hfffe);
		ticks(1);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		ticks(1);
		rd_chk(`TCMP_OFS_FLAGS, 32'h1);
		rd_chk(`TCMP_OFS_CNT_LO, 32'h0);
		ticks(1);
		rd_chk(`TCMP_OFS_FLAGS, 32'h5);
		cpu.wr(`TCMP_OFS_FLAGS, 32'h7);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
	endtask
	// Channel A output mode, optional force, then the pin two cycles on
	task step(input logic [7:0] ctl, input logic f, input logic e);
		cpu.wr(`TCMP_OFS_CTRL, {24'h0, ctl});
		if (f) cpu.wr(`TCMP_OFS_FORCE, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, pin[0]}, {31'h0, e});
	endtask
	task t_force;
		cpu.wr(`TCMP_OFS_PORT, 32'hc);
		step(8'h30, 1'b1, 1'b1);
		step(8'h00, 1'b1, 1'b0);
		step(8'h10, 1'b0, 1'b1);
		step(8'h10, 1'b1, 1'b0);
		step(8'h30, 1'b1, 1'b1);
		step(8'h20, 1'b1, 1'b0);
		step(8'h30, 1'b1, 1'b1);
		step(8'h34, 1'b0, 1'b1);
		cpu.wr(`TCMP_OFS_CTRL, 32'hf4);
		cpu.wr(`TCMP_OFS_FORCE, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({30'h0, pin}, 32'h3);
		rd_chk(`TCMP_OFS_FLAGS, 32'h0);
		chk({30'h0, oe}, 32'h3);
		cpu.wr(`TCMP_OFS_PORT, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({30'h0, oe}, 32'h0);
	endtask
	task t_dbuf;
		cpu.wr(`TCMP_OFS_CTRL, 32'h0);
		cpu.wr16(`TCMP_OFS_CMPA_HI, 16'h0005);
		cpu.wr(`TCMP_OFS_CTRL, 32'h5);
		cpu.wr16(`TCMP_OFS_CMPA_HI, 16'h0007);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0000);
		ticks(6);
		rd_chk(`TCMP_OFS_FLAGS, 32'h2);
		rd_chk(`TCMP_OFS_CMPA_LO, 32'h07);
		cpu.wr(`TCMP_OFS_CTRL, 32'h0);
		rd_chk(`TCMP_OFS_CMPA_LO, 32'h05);
		// Fast PWM with channel A as TOP; the new TOP only takes over at the old one
		cpu.wr16(`TCMP_OFS_CMPA_HI, 16'h0003);
		cpu.wr16(`TCMP_OFS_CMPB_HI, 16'h0001);
		cpu.wr(`TCMP_OFS_CTRL, 32'h8f);
		cpu.wr16(`TCMP_OFS_CMPA_HI, 16'h0005);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0000);
		ticks(8);
		rd_chk(`TCMP_OFS_CNT_LO, 32'h04);
		chk({31'h0, pin[1]}, 32'h0);
		cpu.wr16(`TCMP_OFS_CNT_HI, 16'h0005);
		ticks(1);
		rd_chk(`TCMP_OFS_CNT_LO, 32'h06);
	endtask

	task give_verdict;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_match;
		t_irq;
		t_ovf;
		t_force;
		t_dbuf;
		give_verdict;
	end

	// Whole run is a few hundred cycles; this is a wide margin
	initial begin
		#100000;
		err_total++;
		give_verdict;
	end
endmodule // test_tcmp_top
